// ---- src/cfglk_regs.v ----
// lock, pump, pin mode and duty registers behind the serial port
// assumes serial pins are asynchronous and far slower than core_clk;
// lock level 0 and the charge pump enable live in a neighbouring register
`timescale 1ns/1ns
`include "cfglk_defines.vh"
module cfglk_regs #(
  parameter PWM_STEP_DIV = 16'd4,
  parameter WAKE_FILT_CYC = `CFGLK_WAKE_FILT_NS / `CFGLK_CLK_PERIOD_NS
) (
  // clock and reset (reset is power-up)
  input wire core_clk,
  input wire rst,
  // serial port
  input wire serial_clk,
  input wire serial_data_in,
  input wire serial_select_low,
  output reg serial_data_out_q,
  output wire serial_data_out_oe,
  // system events
  input wire soft_reset_req,
  input wire restart_req,
  input wire failsafe_mode,
  input wire cfg_lock0,
  // pin wake input
  input wire pin_level,
  // configuration outputs
  output wire [2:0] pump_switch_frequency,
  output wire supply_peak_threshold,
  output wire [1:0] spread_modulation_rate,
  output wire cfg_lock1,
  output wire charge_pump_enable_wr_ok,
  output wire [2:0] pin_mode,
  output wire [7:0] duty_value,
  // pin function outputs
  output wire fault_output_sel,
  output wire high_side_switch_on,
  output wire low_side_switch_on,
  output wire timer_hs_sel,
  output reg wake_event_q,
  output wire failsafe_wake_src
);

  // ==========================================
  // input synchronisers
  reg [2:0] sclk_sync_q;
  reg [1:0] sdi_sync_q;
  reg [2:0] csn_sync_q;
  reg [1:0] pin_sync_q;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_sync_q <= 3'h0;
      sdi_sync_q <= 2'h0;
      csn_sync_q <= 3'h7;
      pin_sync_q <= 2'h0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], serial_clk};
      sdi_sync_q <= {sdi_sync_q[0], serial_data_in};
      csn_sync_q <= {csn_sync_q[1:0], serial_select_low};
      pin_sync_q <= {pin_sync_q[0], pin_level};
    end
  end

  wire sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
  wire sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
  wire sel_active = ~csn_sync_q[1];
  wire sel_release = csn_sync_q[1] & ~csn_sync_q[2];

  // ==========================================
  // register state
  reg [7:0] pump_q;
  reg [2:0] pin_q;
  reg [7:0] duty_q;

  // ==========================================
  // read mux, reserved bits as zero
  function [7:0] read_mux;
    input [6:0] addr;
    input [7:0] pump;
    input [2:0] pin;
    input [7:0] duty;
    begin
      case (addr)
        `CFGLK_ADDR_PUMP: read_mux = pump & `CFGLK_PUMP_WMASK; // R10
        `CFGLK_ADDR_PIN: read_mux = {5'h00, pin}; // R10
        `CFGLK_ADDR_DUTY: read_mux = duty;
        default: read_mux = 8'h00;
      endcase
    end
  endfunction

  // pin mode kept on restart or soft reset; switch modes fall back to off, except on soft reset with cfg_lock0 set
  function [2:0] pin_keep;
    input [2:0] pin;
    begin
      case (pin)
        `CFGLK_PIN_TIMER_HS: pin_keep = `CFGLK_PIN_OFF;
        `CFGLK_PIN_PWM_LS: pin_keep = `CFGLK_PIN_OFF;
        `CFGLK_PIN_PWM_HS: pin_keep = `CFGLK_PIN_OFF;
        default: pin_keep = pin;
      endcase
    end
  endfunction

  // ==========================================
  // serial frame: addr[6:0], write flag, data[7:0], lsb first
  reg [4:0] bit_cnt_q;
  reg [15:0] shift_in_q;
  reg [7:0] shift_out_q;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bit_cnt_q <= 5'h00;
      shift_in_q <= 16'h0000;
    end else if (!sel_active) begin
      bit_cnt_q <= 5'h00;
    end else if (sclk_rise) begin
      shift_in_q <= {sdi_sync_q[1], shift_in_q[15:1]};
      // counts one past a full frame so longer frames never commit
      if (bit_cnt_q <= `CFGLK_FRAME_BITS) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // address is complete once eight bits are in
  wire [6:0] frame_addr = shift_in_q[14:8];
  wire addr_done = sel_active & (bit_cnt_q == `CFGLK_ADDR_BITS);

  reg addr_done_q;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_done_q <= 1'b0;
      shift_out_q <= 8'h00;
      serial_data_out_q <= 1'b0;
    end else begin
      addr_done_q <= addr_done;
      if (addr_done & ~addr_done_q) begin
        shift_out_q <= read_mux(frame_addr, pump_q, pin_q, duty_q);
      end else if (sclk_fall && bit_cnt_q > `CFGLK_ADDR_BITS) begin
        shift_out_q <= {1'b0, shift_out_q[7:1]};
      end
      serial_data_out_q <= shift_out_q[0];
    end
  end

  assign serial_data_out_oe = sel_active;

  // ==========================================
  // commit at select release
  wire commit = sel_release & (bit_cnt_q == `CFGLK_FRAME_BITS) &
    shift_in_q[`CFGLK_WR_BIT];
  wire [6:0] wr_addr = shift_in_q[6:0];
  wire [7:0] wr_data = shift_in_q[15:8];
  wire lock1_active = pump_q[`CFGLK_LOCK1_BIT];

  // pump register, restart wins over soft reset
  reg [7:0] pump_d;
  always @* begin
    pump_d = pump_q;
    if (restart_req) begin
      pump_d = pump_q & `CFGLK_PUMP_WMASK;
    end else if (soft_reset_req) begin
      if (!lock1_active) begin
        pump_d = `CFGLK_PUMP_POR;
      end else begin
        pump_d = pump_q & `CFGLK_PUMP_WMASK; // R03
      end
    end else if (commit && wr_addr == `CFGLK_ADDR_PUMP && !lock1_active) begin
      pump_d = wr_data & `CFGLK_PUMP_WMASK; // R04 R05 R06 R20
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pump_q <= `CFGLK_PUMP_POR; // R06
    end else begin
      pump_q <= pump_d;
    end
  end

  // pin mode register; next value also feeds the registered decodes
  reg [2:0] pin_d;
  always @* begin
    pin_d = pin_q;
    if (restart_req) begin
      pin_d = pin_keep(pin_q); // R14
    end else if (soft_reset_req) begin
      if (!cfg_lock0) begin
        pin_d = pin_keep(pin_q); // R14
      end
    end else if (commit && wr_addr == `CFGLK_ADDR_PIN && !cfg_lock0) begin
      pin_d = wr_data[2:0]; // R01 R20
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_q <= `CFGLK_PIN_POR;
    end else begin
      pin_q <= pin_d;
    end
  end

  // duty register, kept on restart
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      duty_q <= `CFGLK_DUTY_POR;
    end else if (soft_reset_req && !restart_req) begin
      duty_q <= `CFGLK_DUTY_POR;
    end else if (commit && wr_addr == `CFGLK_ADDR_DUTY) begin
      duty_q <= wr_data;
    end
  end

  // ==========================================
  // field outputs
  assign pump_switch_frequency = pump_q[`CFGLK_FREQ_HI:`CFGLK_FREQ_LO]; // R07
  assign supply_peak_threshold = pump_q[`CFGLK_PEAK_BIT]; // R08
  assign spread_modulation_rate = pump_q[`CFGLK_SS_HI:`CFGLK_SS_LO]; // R09
  assign cfg_lock1 = lock1_active;
  assign charge_pump_enable_wr_ok = ~cfg_lock0; // R01
  assign pin_mode = pin_q;
  assign duty_value = duty_q;

  // ==========================================
  // pin function decode
  wire wake_sel = (pin_q == `CFGLK_PIN_WAKE); // R12

  // ==========================================
  // pwm step divider and generator
  reg [15:0] div_q;
  wire step_en = (div_q == 16'h0000);
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_q <= 16'h0000;
    end else if (step_en) begin
      div_q <= PWM_STEP_DIV - 16'd1;
    end else begin
      div_q <= div_q - 16'h0001;
    end
  end

  wire pwm_on;
  cfglk_pwm u_pwm (
    .core_clk(core_clk),
    .rst(rst),
    .step_en(step_en),
    .duty_value(duty_q),
    .switch_on_q(pwm_on)
  );

  // switch and decode outputs registered from the next pin mode
  reg fault_sel_q;
  reg timer_sel_q;
  reg fs_wake_q;
  reg ls_on_q;
  reg hs_on_q;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_sel_q <= 1'b1;
      timer_sel_q <= 1'b0;
      fs_wake_q <= 1'b0;
      ls_on_q <= 1'b0;
      hs_on_q <= 1'b0;
    end else begin
      fault_sel_q <= (pin_d < `CFGLK_PIN_TIMER_HS); // R11
      timer_sel_q <= (pin_d == `CFGLK_PIN_TIMER_HS); // R11
      fs_wake_q <= (pin_d == `CFGLK_PIN_WAKE) & failsafe_mode; // R15
      ls_on_q <= (pin_d == `CFGLK_PIN_PWM_LS) & pwm_on; // R13
      hs_on_q <= (pin_d == `CFGLK_PIN_PWM_HS) & pwm_on; // R13
    end
  end

  assign fault_output_sel = fault_sel_q;
  assign timer_hs_sel = timer_sel_q;
  assign failsafe_wake_src = fs_wake_q;
  assign low_side_switch_on = ls_on_q;
  assign high_side_switch_on = hs_on_q;

  // ==========================================
  // wake static filter
  reg [15:0] filt_q;
  reg pin_stable_q;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      filt_q <= 16'h0000;
      pin_stable_q <= 1'b0;
      wake_event_q <= 1'b0;
    end else begin
      wake_event_q <= 1'b0;
      if (!wake_sel || pin_sync_q[1] == pin_stable_q) begin
        filt_q <= 16'h0000;
      end else if (filt_q == WAKE_FILT_CYC[15:0] - 16'h0001) begin
        filt_q <= 16'h0000;
        pin_stable_q <= pin_sync_q[1];
        wake_event_q <= 1'b1; // R12
      end else begin
        filt_q <= filt_q + 16'h0001;
      end
    end
  end
endmodule

// ---- src/cfglk_defines.vh ----
// constants for the lock, pump, pin mode and duty configuration registers
// assumes a serial frame of 16 bits, sampled on core_clk well above the serial clock
// Overview of operation
// [R01] lock level 0 set: charge pump enable and pin mode changes rejected
// [R02] controller clears lock level 0 before changing pump enable or pin mode
// [R03] soft reset leaves bits of a set lock unchanged, like restart
// [R04] lock level 1 freezes all lockable bits except pump enable and pin mode
// [R05] lock level 1 takes effect at the select low-to-high transition
// [R06] active lock level 1 unwritable, kept over soft reset, cleared at power-up
// [R07] pump frequency bits 7:5: 1.8/2.0/2.2/2.4MHz, 001 default, rest reserved; reset loads 010
// [R08] bit 4 selects low (0) or high (1) peak-current threshold
// [R09] spread bits 3:2: off, or 15.625/31.250/62.500kHz modulation
// [R10] reserved bit 1 and pin mode bits 7:3 read as zero
// [R11] pin mode 000-010 fault output, 011 timer high side, 100 off
// [R12] pin mode 101 wake input with 16us static filter
// [R13] pin mode 110 PWM low side, 111 PWM high side
// [R14] pin mode after restart or soft reset depends on previous mode
// [R15] wake-input pin is a default wake source in fail-safe mode
// [R16] duty zero keeps switch off, all ones keeps it on
// [R17] other duty values: on for value/255 of each period
// [R18] new duty value applies only after current period completes
// [R19] controller should program duty before selecting a PWM pin mode
// [R20] write to locked bits keeps them, unlocked bits still update
`ifndef CFGLK_DEFINES_VH
`define CFGLK_DEFINES_VH

// register addresses
`define CFGLK_ADDR_PUMP 7'h0F
`define CFGLK_ADDR_PIN 7'h17
`define CFGLK_ADDR_DUTY 7'h18

// reset values
`define CFGLK_PUMP_POR 8'h40
`define CFGLK_PIN_POR 3'h0
`define CFGLK_DUTY_POR 8'h00

// pump register fields
`define CFGLK_FREQ_HI 7
`define CFGLK_FREQ_LO 5
`define CFGLK_PEAK_BIT 4
`define CFGLK_SS_HI 3
`define CFGLK_SS_LO 2
`define CFGLK_RSVD_BIT 1
`define CFGLK_LOCK1_BIT 0
`define CFGLK_PUMP_WMASK 8'hFD

// pin modes and a reserved pump frequency code
`define CFGLK_PIN_TIMER_HS 3'h3
`define CFGLK_PIN_OFF 3'h4
`define CFGLK_PIN_WAKE 3'h5
`define CFGLK_PIN_PWM_LS 3'h6
`define CFGLK_PIN_PWM_HS 3'h7
`define CFGLK_FREQ_RSVD 3'h4

// duty extremes and period length
`define CFGLK_DUTY_OFF 8'h00
`define CFGLK_DUTY_ON 8'hFF
`define CFGLK_PWM_LAST 8'hFE

// serial frame
`define CFGLK_FRAME_BITS 5'h10
`define CFGLK_ADDR_BITS 5'h08
`define CFGLK_WR_BIT 7

// wake filter time
`define CFGLK_WAKE_FILT_NS 16000
`define CFGLK_CLK_PERIOD_NS 50

`endif

// ---- src/cfglk_pwm.v ----
// pwm generator for the multipurpose pin switch
// assumes a one-cycle step enable from the parent divider
`timescale 1ns/1ns
module cfglk_pwm (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // control
  input wire step_en,
  input wire [7:0] duty_value,
  // output
  output reg switch_on_q
);
  `include "cfglk_defines.vh"

  reg [7:0] phase_q;
  reg [7:0] duty_act_q;

  // ==========================================
  // period counter and duty latch
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_q <= 8'h00;
      duty_act_q <= `CFGLK_DUTY_POR;
    end else if (step_en) begin
      if (phase_q == `CFGLK_PWM_LAST) begin
        phase_q <= 8'h00;
        duty_act_q <= duty_value; // R18
      end else begin
        phase_q <= phase_q + 8'h01;
      end
    end
  end

  // ==========================================
  // switch output, 255 steps per period
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      switch_on_q <= 1'b0;
    end else if (duty_act_q == `CFGLK_DUTY_OFF) begin
      switch_on_q <= 1'b0; // R16
    end else if (duty_act_q == `CFGLK_DUTY_ON) begin
      switch_on_q <= 1'b1; // R16
    end else begin
      switch_on_q <= (phase_q < duty_act_q); // R17
    end
  end
endmodule

// ---- tb/cfglk_checker.sv ----
// assertions on the lock, pump, pin mode and pwm outputs
// assumes bound to cfglk_regs, sees only its ports
`timescale 1ns/1ns
module cfglk_checker (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // events
  input wire soft_reset_req,
  input wire restart_req,
  input wire failsafe_mode,
  input wire cfg_lock0,
  // serial select and read drive enable
  input wire serial_select_low,
  input wire serial_data_out_oe,
  // fields and decodes
  input wire [2:0] pump_switch_frequency,
  input wire supply_peak_threshold,
  input wire [1:0] spread_modulation_rate,
  input wire cfg_lock1,
  input wire charge_pump_enable_wr_ok,
  input wire [2:0] pin_mode,
  input wire fault_output_sel,
  input wire timer_hs_sel,
  input wire low_side_switch_on,
  input wire high_side_switch_on,
  input wire failsafe_wake_src
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire [5:0] pf = {pump_switch_frequency, supply_peak_threshold, spread_modulation_rate};
  a_pump_en_lock: assert property (charge_pump_enable_wr_ok == !cfg_lock0)
    else $error("pump enable write permission wrong");
  a_pin_held_lock0: assert property (cfg_lock0 && $past(cfg_lock0) && !restart_req &&
    !$past(restart_req) |=> $stable(pin_mode)) else $error("pin mode changed under lock");
  a_lock1_keep: assert property (cfg_lock1 |=> cfg_lock1)
    else $error("lock level 1 dropped");
  a_lock1_freeze: assert property (cfg_lock1 |=> $stable(pf))
    else $error("pump fields changed under lock");
  a_soft_default: assert property (soft_reset_req && !restart_req && !cfg_lock1
    |-> ##[1:2] pf == 6'h10) else $error("pump fields not default after soft reset");
  a_fault_decode: assert property (fault_output_sel == (pin_mode < 3'h3))
    else $error("fault output select wrong");
  a_timer_decode: assert property (timer_hs_sel == (pin_mode == 3'h3))
    else $error("timer switch select wrong");
  a_switch_gate: assert property ((low_side_switch_on |-> pin_mode == 3'h6) and
    (high_side_switch_on |-> pin_mode == 3'h7)) else $error("switch on in wrong mode");
  a_wake_source: assert property ($past(failsafe_mode) && pin_mode == 3'h5 |-> failsafe_wake_src)
    else $error("wake input not a fail-safe wake source");
  a_oe_select: assert property (serial_data_out_oe == !$past(serial_select_low, 2))
    else $error("read drive enable does not follow select");
  c_lock1: cover property (cfg_lock1 && soft_reset_req);
  c_low_side: cover property (low_side_switch_on);
  c_high_side: cover property (high_side_switch_on);
endmodule
bind cfglk_regs cfglk_checker u_cfglk_checker (.core_clk(core_clk), .rst(rst),
  .soft_reset_req(soft_reset_req), .restart_req(restart_req),
  .failsafe_mode(failsafe_mode), .cfg_lock0(cfg_lock0),
  .serial_select_low(serial_select_low), .serial_data_out_oe(serial_data_out_oe),
  .pump_switch_frequency(pump_switch_frequency), .supply_peak_threshold(supply_peak_threshold),
  .spread_modulation_rate(spread_modulation_rate), .cfg_lock1(cfg_lock1),
  .charge_pump_enable_wr_ok(charge_pump_enable_wr_ok), .pin_mode(pin_mode),
  .fault_output_sel(fault_output_sel), .timer_hs_sel(timer_hs_sel),
  .low_side_switch_on(low_side_switch_on), .high_side_switch_on(high_side_switch_on),
  .failsafe_wake_src(failsafe_wake_src));

// ---- tb/cfglk_mcu.sv ----
// microcontroller model on the serial port
// assumes core_clk far faster than the serial clock
`timescale 1ns/1ns
module cfglk_mcu (
  // clock
  input wire core_clk,
  // serial pins
  output reg serial_clk,
  output reg serial_data_in,
  output reg serial_select_low,
  input wire serial_data_out_q
);
  initial begin
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
    serial_select_low = 1'b1;
  end
  // address lsb first, write flag, data lsb first; n bits sent
  task automatic xfer(input [6:0] a, input w, input [7:0] d, input [4:0] n, output [7:0] q);
    reg [15:0] f;
    integer i;
    begin
      f = {d, w, a};
      q = 8'h00;
      @(posedge core_clk) serial_select_low <= 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge core_clk) serial_data_in <= f[i];
        repeat (5) @(posedge core_clk);
        serial_clk <= 1'b1;
        if (i > 7) q[i - 8] = serial_data_out_q;
        repeat (5) @(posedge core_clk);
        serial_clk <= 1'b0;
      end
      repeat (5) @(posedge core_clk);
      serial_select_low <= 1'b1;
      // released line flips so stale data is never mistaken
      serial_data_in <= ~serial_data_in;
      repeat (8) @(posedge core_clk);
    end
  endtask
endmodule

// ---- tb/config_lock_pin_pwm_regs_bench.sv ----
// self-checking bench for the config register block
// assumes the serial model and the bound checker
`timescale 1ns/1ns
module config_lock_pin_pwm_regs_bench;
  reg core_clk = 1'b0, rst = 1'b1, soft_reset_req = 1'b0, restart_req = 1'b0;
  reg failsafe_mode = 1'b0, cfg_lock0 = 1'b0, pin_level = 1'b0;
  wire sclk, sdi, ssel, sdo, lock1, ls, hs, wake, peak;
  wire [2:0] freq, pin;
  wire [1:0] ss;
  wire [7:0] duty;
  integer miscompares = 0, checked = 0, i, n, k;
  reg [7:0] q;
  always #25 core_clk = ~core_clk;
  cfglk_mcu u_cfglk_mcu (.core_clk(core_clk), .serial_clk(sclk), .serial_data_in(sdi),
    .serial_select_low(ssel), .serial_data_out_q(sdo));
  cfglk_regs #(.PWM_STEP_DIV(16'd1), .WAKE_FILT_CYC(8)) u_cfglk_regs (
    .core_clk(core_clk), .rst(rst), .serial_clk(sclk), .serial_data_in(sdi),
    .serial_select_low(ssel), .serial_data_out_q(sdo), .serial_data_out_oe(),
    .soft_reset_req(soft_reset_req), .restart_req(restart_req),
    .failsafe_mode(failsafe_mode), .cfg_lock0(cfg_lock0), .pin_level(pin_level),
    .pump_switch_frequency(freq), .supply_peak_threshold(peak),
    .spread_modulation_rate(ss), .cfg_lock1(lock1), .charge_pump_enable_wr_ok(),
    .pin_mode(pin), .duty_value(duty), .fault_output_sel(), .high_side_switch_on(hs),
    .low_side_switch_on(ls), .timer_hs_sel(), .wake_event_q(wake), .failsafe_wake_src());
  task automatic chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task automatic wr(input [6:0] a, input [7:0] d);
    u_cfglk_mcu.xfer(a, 1'b1, d, 5'h10, q);
  endtask
  task automatic rd(input [6:0] a, input [7:0] e);
    begin
      u_cfglk_mcu.xfer(a, 1'b0, 8'h00, 5'h10, q);
      chk("read", e, q);
    end
  endtask
  task automatic pulse(input integer r);
    begin
      @(posedge core_clk);
      if (r) restart_req <= 1'b1;
      else soft_reset_req <= 1'b1;
      @(posedge core_clk);
      restart_req <= 1'b0;
      soft_reset_req <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask
  task t_pump;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        n = {i[2:0], i[0], i[1:0], 2'b10};
        wr(7'h0F, n[7:0]);
        chk("freq", i, freq);
        chk("peak", i & 1, peak);
        chk("spread", i, ss);
        rd(7'h0F, n[7:0] & 8'hFC);
      end
      u_cfglk_mcu.xfer(7'h0F, 1'b1, 8'h00, 5'h0F, q);
      rd(7'h0F, 8'h7C);
      rd(7'h33, 8'h00);
    end
  endtask
  task t_pin;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        wr(7'h17, {5'h1F, i[2:0]});
        rd(7'h17, i);
        chk("pin", i, pin);
      end
      @(posedge core_clk) cfg_lock0 <= 1'b1;
      wr(7'h17, 8'h02);
      chk("locked pin", 7, pin);
      @(posedge core_clk) cfg_lock0 <= 1'b0;
      wr(7'h17, 8'h02);
      chk("pin", 2, pin);
    end
  endtask
  task t_pwm;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        n = 127 * i + (i == 2);
        wr(7'h18, n[7:0]);
        rd(7'h18, n[7:0]);
        chk("duty", n, duty);
        wr(7'h17, {5'h00, 2'b11, i[0]});
        repeat (300) @(posedge core_clk);
        k = 0;
        repeat (255) begin
          @(negedge core_clk);
          k = k + (i[0] ? hs : ls);
        end
        chk("on count", n, k);
      end
    end
  endtask
  task t_soft;
    begin
      wr(7'h0F, 8'h6C);
      wr(7'h18, 8'h55);
      wr(7'h17, 8'h05);
      pulse(0);
      rd(7'h0F, 8'h40);
      rd(7'h18, 8'h00);
      rd(7'h17, 8'h05);
      @(posedge core_clk) failsafe_mode <= 1'b1;
      @(posedge core_clk) pin_level <= 1'b1;
      k = 0;
      while (k < 40 && wake !== 1'b1) begin
        @(negedge core_clk);
        k = k + 1;
      end
      chk("wake", 1, wake);
      wr(7'h18, 8'h55);
      wr(7'h17, 8'h07);
      pulse(1);
      rd(7'h18, 8'h55);
      rd(7'h17, 8'h04);
    end
  endtask
  task t_lock1;
    begin
      wr(7'h0F, 8'h31);
      chk("lock1", 1, lock1);
      wr(7'h0F, 8'h6C);
      rd(7'h0F, 8'h31);
      pulse(0);
      rd(7'h0F, 8'h31);
      @(posedge core_clk) cfg_lock0 <= 1'b1;
      wr(7'h17, 8'h06);
      pulse(0);
      rd(7'h17, 8'h04);
      @(posedge core_clk) cfg_lock0 <= 1'b0;
      wr(7'h17, 8'h06);
      chk("pin", 6, pin);
      @(posedge core_clk) rst <= 1'b1;
      @(posedge core_clk) rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      rd(7'h0F, 8'h40);
    end
  endtask
  task complete_run;
    begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(7'h0F, 8'h40);
    rd(7'h17, 8'h00);
    t_pump;
    t_pin;
    t_pwm;
    t_soft;
    t_lock1;
    complete_run;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares = miscompares + 1;
    complete_run;
  end
endmodule
